// [logic/serial_gpio_defs.vh]
// constants for the serial-shared gpio port: offsets, fields, reset values
`ifndef SERIAL_GPIO_DEFS_VH
`define SERIAL_GPIO_DEFS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define OFF_PIN_DATA 12'h000
`define OFF_PIN_DIRECTION 12'h004
`define OFF_SYNC_CTRL_ONE 12'h008
`define OFF_SYNC_CTRL_TWO 12'h00C
`define OFF_ASYNC0_CTRL_ONE 12'h010
`define OFF_ASYNC1_CTRL_ONE 12'h014

// ----------------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------------
`define SEL_NONE 3'h0
`define SEL_DATA 3'h1
`define SEL_DIR 3'h2
`define SEL_SYNC1 3'h3
`define SEL_SYNC2 3'h4
`define SEL_ASY0 3'h5
`define SEL_ASY1 3'h6

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BIT_SYNC_ENABLE 6
`define BIT_SYNC_WIRED_OR 5
`define BIT_PULLUP_ENABLE 3
`define BIT_REDUCED_DRIVE 2
`define BIT_SERIAL_PIN_CTRL 0
`define BIT_ASYNC_LOOP 7
`define BIT_ASYNC_WIRED_OR 6

// ----------------------------------------------------------------------
// pin positions and groups
// ----------------------------------------------------------------------
`define PIN_ASYNC0_RX 0
`define PIN_ASYNC0_TX 1
`define PIN_ASYNC1_RX 2
`define PIN_ASYNC1_TX 3
`define PIN_SYNC_LO 4
`define PIN_SYNC_HI 7

// ----------------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_SYNC_CTRL_TWO 8'h08
`define RST_PULLUP_ALL 8'hFF
`define RST_WORD 32'h0000_0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define MASK_CTRL_TWO 8'h0D

`endif

// [logic/serial_gpio_pin_cell.v]
// one port pin: direction, serial steering, wired-or and read-back
`timescale 1ns/1ps
module serial_gpio_pin_cell
(
  // port latch and direction
  input wire i_latch,
  input wire i_dir,
  // serial function steering
  input wire i_force_in,
  input wire i_force_out,
  input wire i_serial_own,
  input wire i_serial_val,
  // options
  input wire i_wired_or,
  input wire i_pullup_en,
  // pin level
  input wire i_pin_in,
  // results
  output reg o_out,
  output reg o_oe,
  output reg o_pullup,
  output reg o_read
);

  reg is_out;
  reg drv_in;

  // steering of one pin
  always @*
  begin
    // serial forcing overrides the direction bit
    is_out = i_force_out | (i_dir & ~i_force_in); // [R08] [R09] [R10] [R11]
    // serial value replaces the latch, so writes cannot move the pin
    drv_in = i_serial_own ? i_serial_val : i_latch; // [R06] [R07]
    if (i_wired_or)
    begin
      o_out = 1'b0; // [R16]
      o_oe = is_out & ~drv_in; // [R16]
    end
    else
    begin
      o_out = drv_in;
      o_oe = is_out; // [R06]
    end
    o_pullup = i_pullup_en & ~is_out; // [R12]
    // direction-1 pins read the driver input, direction-0 pins the pin level
    o_read = i_dir ? drv_in : i_pin_in; // [R04] [R05]
  end

endmodule

// [logic/serial_gpio_port.v]
// eight-bit gpio port sharing its pins with two async and one sync channel
//
// Overview of operation
// [R01] every pin works either as plain gpio or for its serial function
// [R02] upper four pins carry sync select, clock, master-out and master-in
// [R03] lower four pins carry transmit and receive of both async channels
// [R04] reading a data bit with direction 0 returns the pin level
// [R05] reading a data bit with direction 1 returns the driver input value
// [R06] writes land in a latch that drives the pin only when output
// [R07] data writes do not move a pin used as async serial output
// [R08] direction 1 means output, 0 input; reset clears all to input
// [R09] loop bit 0: async receive pins input, transmit pins output
// [R10] sync channel enabled: its input pins are forced to inputs
// [R11] sync enabled: its outputs drive only with direction 1, else gpio
// [R12] pull-up bit enables pull-ups on input pins only; set after reset
// [R13] reduced-drive bit lowers drive on outputs; clear after reset
// [R14] wired-or in three groups: sync upper four, each async its pair; here each async bit sets the other channel's pair
// [R15] software may access data and direction registers at any time
// [R16] wired-or output drives low only and releases for a high
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "serial_gpio_defs.vh"
module serial_gpio_port
(
  // clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // axi4-lite write address and data
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [11:0] i_s_axi_awaddr,
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  // axi4-lite write response
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  output reg [1:0] o_s_axi_bresp,
  // axi4-lite read
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  input wire [11:0] i_s_axi_araddr,
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  // port pins
  input wire [7:0] i_pin_in,
  output reg [7:0] o_pin_out,
  output reg [7:0] o_pin_oe,
  output reg [7:0] o_pin_pullup,
  output reg o_reduced_drive,
  // async channels
  input wire i_async0_tx_val,
  input wire i_async1_tx_val,
  output reg o_async0_rx_val,
  output reg o_async1_rx_val,
  output reg o_async0_loop,
  output reg o_async1_loop,
  // sync channel, select, clock, master-out, master-in
  input wire [3:0] i_sync_out_mask,
  input wire [3:0] i_sync_out_val,
  output reg [3:0] o_sync_in_val,
  output reg o_sync_enable,
  output reg o_serial_pin_control
);

  // --------------------------------------------------------------------
  // register file
  // --------------------------------------------------------------------
  reg [7:0] pin_data_ff;
  reg [7:0] pin_dir_ff;
  reg [7:0] sync_ctrl_one_ff;
  reg [7:0] sync_ctrl_two_ff;
  reg [7:0] async0_ctrl_one_ff;
  reg [7:0] async1_ctrl_one_ff;
  reg aw_held_ff;
  reg [11:0] aw_addr_ff;
  reg w_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;

  // per-pin steering vectors
  reg [7:0] force_in;
  reg [7:0] force_out;
  reg [7:0] serial_own;
  reg [7:0] serial_val;
  reg [7:0] wired_or;
  wire [7:0] cell_out;
  wire [7:0] cell_oe;
  wire [7:0] cell_pullup;
  wire [7:0] cell_read;

  wire sync_on;
  wire loop0;
  wire loop1;
  wire do_write;
  wire [2:0] wsel;
  wire [2:0] rsel;

  // address decode shared by the write and read paths
  function [2:0] reg_sel;
    input [11:0] addr;
    begin
      case (addr)
        `OFF_PIN_DATA: reg_sel = `SEL_DATA;
        `OFF_PIN_DIRECTION: reg_sel = `SEL_DIR;
        `OFF_SYNC_CTRL_ONE: reg_sel = `SEL_SYNC1;
        `OFF_SYNC_CTRL_TWO: reg_sel = `SEL_SYNC2;
        `OFF_ASYNC0_CTRL_ONE: reg_sel = `SEL_ASY0;
        `OFF_ASYNC1_CTRL_ONE: reg_sel = `SEL_ASY1;
        default: reg_sel = `SEL_NONE;
      endcase
    end
  endfunction

  assign sync_on = sync_ctrl_one_ff[`BIT_SYNC_ENABLE];
  assign loop0 = async0_ctrl_one_ff[`BIT_ASYNC_LOOP];
  assign loop1 = async1_ctrl_one_ff[`BIT_ASYNC_LOOP];
  // a write completes once both address and data are held
  assign do_write = aw_held_ff & w_held_ff & ~o_s_axi_bvalid;
  assign wsel = reg_sel(aw_addr_ff);
  assign rsel = reg_sel(i_s_axi_araddr);

  // --------------------------------------------------------------------
  // axi write channels; address and data are taken in either order
  // --------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 12'h000;
      w_data_ff <= `RST_WORD;
      w_strb_ff <= 4'h0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      // each ready is offered only while its own channel holds nothing, so one write at a time
      o_s_axi_awready <= ~aw_held_ff & ~(o_s_axi_awready & i_s_axi_awvalid);
      o_s_axi_wready <= ~w_held_ff & ~(o_s_axi_wready & i_s_axi_wvalid);
      if (o_s_axi_awready & i_s_axi_awvalid)
      begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= i_s_axi_awaddr;
      end
      if (o_s_axi_wready & i_s_axi_wvalid)
      begin
        w_held_ff <= 1'b1;
        w_data_ff <= i_s_axi_wdata;
        w_strb_ff <= i_s_axi_wstrb;
      end
      if (do_write)
      begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp <= (wsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      else if (o_s_axi_bvalid & i_s_axi_bready)
      begin
        o_s_axi_bvalid <= 1'b0;
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // register updates; only byte lane 0 carries data
  // --------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pin_data_ff <= `RST_BYTE;
      pin_dir_ff <= `RST_BYTE; // [R08]
      sync_ctrl_one_ff <= `RST_BYTE; // [R14]
      sync_ctrl_two_ff <= `RST_SYNC_CTRL_TWO; // [R12] [R13]
      async0_ctrl_one_ff <= `RST_BYTE; // [R14]
      async1_ctrl_one_ff <= `RST_BYTE; // [R14]
    end
    else if (do_write & w_strb_ff[0])
    begin
      // no access window: data and direction accept writes any time
      case (wsel)
        `SEL_DATA: pin_data_ff <= w_data_ff[7:0]; // [R06] [R15]
        `SEL_DIR: pin_dir_ff <= w_data_ff[7:0]; // [R08] [R15]
        `SEL_SYNC1: sync_ctrl_one_ff <= w_data_ff[7:0];
        `SEL_SYNC2: sync_ctrl_two_ff <= w_data_ff[7:0] & `MASK_CTRL_TWO;
        `SEL_ASY0: async0_ctrl_one_ff <= w_data_ff[7:0];
        `SEL_ASY1: async1_ctrl_one_ff <= w_data_ff[7:0];
        default: pin_data_ff <= pin_data_ff;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // axi read channel; data bits show the sampled pin or driver input
  // --------------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= `RST_WORD;
      o_s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      o_s_axi_arready <= ~o_s_axi_rvalid & ~o_s_axi_arready;
      if (o_s_axi_arready & i_s_axi_arvalid)
      begin
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rresp <= (rsel == `SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        case (rsel)
          `SEL_DATA: o_s_axi_rdata <= {24'h00_0000, cell_read}; // [R04] [R05]
          `SEL_DIR: o_s_axi_rdata <= {24'h00_0000, pin_dir_ff};
          `SEL_SYNC1: o_s_axi_rdata <= {24'h00_0000, sync_ctrl_one_ff};
          `SEL_SYNC2: o_s_axi_rdata <= {24'h00_0000, sync_ctrl_two_ff};
          `SEL_ASY0: o_s_axi_rdata <= {24'h00_0000, async0_ctrl_one_ff};
          `SEL_ASY1: o_s_axi_rdata <= {24'h00_0000, async1_ctrl_one_ff};
          default: o_s_axi_rdata <= `RST_WORD;
        endcase
      end
      else if (o_s_axi_rvalid & i_s_axi_rready)
      begin
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // serial steering per pin
  // --------------------------------------------------------------------
  // with loop mode clear the async pair ignores direction; in loop mode
  // the pair falls back to plain gpio so the channel keeps off the pins
  always @*
  begin
    force_in = 8'h00;
    force_out = 8'h00;
    serial_own = 8'h00;
    serial_val = 8'h00;
    force_in[`PIN_ASYNC0_RX] = ~loop0; // [R03] [R09]
    force_out[`PIN_ASYNC0_TX] = ~loop0; // [R03] [R09]
    serial_own[`PIN_ASYNC0_TX] = ~loop0; // [R07]
    serial_val[`PIN_ASYNC0_TX] = i_async0_tx_val;
    force_in[`PIN_ASYNC1_RX] = ~loop1; // [R03] [R09]
    force_out[`PIN_ASYNC1_TX] = ~loop1; // [R03] [R09]
    serial_own[`PIN_ASYNC1_TX] = ~loop1; // [R07]
    serial_val[`PIN_ASYNC1_TX] = i_async1_tx_val;
    // sync pins: inputs forced, outputs still gated by direction
    force_in[`PIN_SYNC_HI:`PIN_SYNC_LO] =
      {4{sync_on}} & ~i_sync_out_mask; // [R02] [R10]
    serial_own[`PIN_SYNC_HI:`PIN_SYNC_LO] =
      {4{sync_on}} & i_sync_out_mask; // [R02] [R11]
    serial_val[`PIN_SYNC_HI:`PIN_SYNC_LO] = i_sync_out_val;
    // wired-or groups follow the three group control bits
    wired_or[`PIN_SYNC_HI:`PIN_SYNC_LO] =
      {4{sync_ctrl_one_ff[`BIT_SYNC_WIRED_OR]}}; // [R14]
    wired_or[`PIN_ASYNC1_TX:`PIN_ASYNC1_RX] =
      {2{async0_ctrl_one_ff[`BIT_ASYNC_WIRED_OR]}}; // [R14]
    wired_or[`PIN_ASYNC0_TX:`PIN_ASYNC0_RX] =
      {2{async1_ctrl_one_ff[`BIT_ASYNC_WIRED_OR]}}; // [R14]
  end

  // one cell per pin, any pin may be gpio or serial
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_pin
      serial_gpio_pin_cell u_cell
      (
        .i_latch(pin_data_ff[gi]),
        .i_dir(pin_dir_ff[gi]),
        .i_force_in(force_in[gi]),
        .i_force_out(force_out[gi]),
        .i_serial_own(serial_own[gi]),
        .i_serial_val(serial_val[gi]),
        .i_wired_or(wired_or[gi]),
        .i_pullup_en(sync_ctrl_two_ff[`BIT_PULLUP_ENABLE]),
        .i_pin_in(i_pin_in[gi]),
        .o_out(cell_out[gi]),
        .o_oe(cell_oe[gi]),
        .o_pullup(cell_pullup[gi]),
        .o_read(cell_read[gi])
      ); // [R01]
    end
  endgenerate

  // --------------------------------------------------------------------
  // registered pin and channel outputs
  // --------------------------------------------------------------------
  // one cycle of latency buys glitch-free pins straight from flops
  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_pin_out <= `RST_BYTE;
      o_pin_oe <= `RST_BYTE; // [R08]
      o_pin_pullup <= `RST_PULLUP_ALL; // [R12]
      o_reduced_drive <= 1'b0; // [R13]
      o_async0_rx_val <= 1'b0;
      o_async1_rx_val <= 1'b0;
      o_async0_loop <= 1'b0;
      o_async1_loop <= 1'b0;
      o_sync_in_val <= 4'h0;
      o_sync_enable <= 1'b0;
      o_serial_pin_control <= 1'b0;
    end
    else
    begin
      o_pin_out <= cell_out;
      o_pin_oe <= cell_oe;
      o_pin_pullup <= cell_pullup; // [R12]
      o_reduced_drive <= sync_ctrl_two_ff[`BIT_REDUCED_DRIVE]; // [R13]
      o_async0_rx_val <= i_pin_in[`PIN_ASYNC0_RX];
      o_async1_rx_val <= i_pin_in[`PIN_ASYNC1_RX];
      o_async0_loop <= loop0;
      o_async1_loop <= loop1;
      o_sync_in_val <= i_pin_in[`PIN_SYNC_HI:`PIN_SYNC_LO];
      o_sync_enable <= sync_on;
      o_serial_pin_control <= sync_ctrl_two_ff[`BIT_SERIAL_PIN_CTRL];
    end
  end

endmodule

// [sim/pin_partner.sv]
// partner model: board wiring of the eight port pins
`timescale 1ns/1ps
module pin_partner
(
  // port side
  input wire [7:0] i_out,
  input wire [7:0] i_oe,
  input wire [7:0] i_pullup,
  // external drivers
  input wire [7:0] i_ext_en,
  input wire [7:0] i_ext_val,
  // resolved level
  output wire [7:0] o_level
);
  // ----------------------------------------------------------------------
  // pin resolution
  // ----------------------------------------------------------------------
  // a floating pin without pull-up shows the inverse of the port's value
  // so that a stale level can never pass for a real one
  assign o_level = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val) |
    (~i_oe & ~i_ext_en & (i_pullup | ~i_out));
endmodule

// [sim/serial_gpio_port_asserts.sv]
// assertion checker for the serial-shared gpio port
`timescale 1ns/1ps
module serial_gpio_port_asserts
(
  // clock and reset
  input wire i_core_clk,
  input wire i_resetn,
  // bus answers
  input wire o_s_axi_awready,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire o_s_axi_rvalid,
  input wire i_s_axi_rready,
  input wire [31:0] o_s_axi_rdata,
  // pins
  input wire [7:0] i_pin_in,
  input wire [7:0] o_pin_out,
  input wire [7:0] o_pin_oe,
  input wire [7:0] o_pin_pullup,
  // serial channels
  input wire i_async0_tx_val,
  input wire o_async0_rx_val,
  input wire o_async1_rx_val,
  input wire o_async0_loop,
  input wire [3:0] i_sync_out_mask,
  input wire [3:0] o_sync_in_val,
  input wire o_sync_enable
);
  // ----------------------------------------------------------------------
  // pin checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  AST_PULLUP_OUT: assert property (
    (o_pin_pullup & o_pin_oe) == 8'h00)
    else $error("pull-up active on a driven pin");
  AST_RX0_FOLLOW: assert property (
    $past(i_resetn) |-> o_async0_rx_val == $past(i_pin_in[0]))
    else $error("async0 receive level not passed on");
  AST_RX1_FOLLOW: assert property (
    $past(i_resetn) |-> o_async1_rx_val == $past(i_pin_in[2]))
    else $error("async1 receive level not passed on");
  AST_SYNC_IN: assert property (
    $past(i_resetn) |-> o_sync_in_val == $past(i_pin_in[7:4]))
    else $error("sync pin levels not passed on");
  // loop bit held for two samples, though pins and o_async0_loop lag the register by the same one cycle
  AST_TX0_LOW: assert property (
    $past(i_resetn) && !o_async0_loop && !$past(o_async0_loop) &&
    !$past(i_async0_tx_val) |-> o_pin_oe[1] && !o_pin_out[1])
    else $error("async0 transmit low not driven");
  AST_RX0_INPUT: assert property (
    $past(i_resetn) && !o_async0_loop && !$past(o_async0_loop)
    |-> !o_pin_oe[0])
    else $error("async0 receive pin driven");
  AST_SYNC_FORCED_IN: assert property (
    o_sync_enable && $past(o_sync_enable)
    |-> (o_pin_oe[7:4] & ~$past(i_sync_out_mask)) == 4'h0)
    else $error("sync input pin driven");
  // ----------------------------------------------------------------------
  // bus checks
  // ----------------------------------------------------------------------
  AST_BVALID_HOLD: assert property (
    o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write response dropped early");
  AST_RVALID_HOLD: assert property (
    o_s_axi_rvalid && !i_s_axi_rready
    |=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
    else $error("read answer dropped or changed");
  AST_AW_BLOCKED: assert property (
    o_s_axi_bvalid |-> !o_s_axi_awready)
    else $error("write address accepted during response");
endmodule

bind serial_gpio_port serial_gpio_port_asserts u_chk
(
  .i_core_clk, .i_resetn, .o_s_axi_awready, .o_s_axi_bvalid,
  .i_s_axi_bready, .o_s_axi_rvalid, .i_s_axi_rready, .o_s_axi_rdata,
  .i_pin_in, .o_pin_out, .o_pin_oe, .o_pin_pullup, .i_async0_tx_val,
  .o_async0_rx_val, .o_async1_rx_val, .o_async0_loop, .i_sync_out_mask,
  .o_sync_in_val, .o_sync_enable
);

// [sim/tb.sv]
// self-checking bench for the serial-shared gpio port
`timescale 1ns/1ps
`include "serial_gpio_defs.vh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  failures++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
  // stimulus and observed signals
  logic i_core_clk = 0;
  logic i_resetn = 0;
  logic awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, tx0 = 0, tx1 = 1;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0;
  logic [3:0] ws = 0, mask = 0, sval = 0;
  logic [7:0] ext_en = 8'hFF, ext_val = 8'h00;
  wire awready, wready, bvalid, arready, rvalid, rcv0, rcv1, lp0, spc, sen;
  wire red, lp1;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [7:0] pin_in, pout, poe, ppu;
  int failures = 0;
  int checks_done = 0;

  serial_gpio_port dut
  (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awready),
    .i_s_axi_awaddr(awa), .i_s_axi_wvalid(wv), .o_s_axi_wready(wready),
    .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arready),
    .i_s_axi_araddr(ara), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .i_pin_in(pin_in), .o_pin_out(pout), .o_pin_oe(poe),
    .o_pin_pullup(ppu), .o_reduced_drive(red), .i_async0_tx_val(tx0),
    .i_async1_tx_val(tx1), .o_async0_rx_val(rcv0), .o_async1_rx_val(rcv1),
    .o_async0_loop(lp0), .o_async1_loop(lp1), .i_sync_out_mask(mask),
    .i_sync_out_val(sval), .o_sync_in_val(), .o_sync_enable(sen),
    .o_serial_pin_control(spc)
  );
  pin_partner u_pins
  (
    .i_out(pout), .i_oe(poe), .i_pullup(ppu), .i_ext_en(ext_en),
    .i_ext_val(ext_val), .o_level(pin_in)
  );

  // free-running core clock
  always #5 i_core_clk = ~i_core_clk;

  // ----------------------------------------------------------------------
  // closing and bus tasks
  // ----------------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic timed_out();
    failures++;
    finish_test();
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask

  // late bready lets the held response be seen waiting
  task automatic wr(input [11:0] a, input [7:0] d, input [3:0] s,
    input [1:0] er);
    int n;
    n = 0;
    awv <= 1;
    wv <= 1;
    awa <= a;
    wd <= {24'h0000, d};
    ws <= s;
    do
    begin
      @(posedge i_core_clk);
      n++;
      if (awready === 1'b1)
        awv <= 0;
      if (wready === 1'b1)
        wv <= 0;
      if (n == 3)
        bready <= 1;
    end while (!(bvalid === 1'b1 && bready === 1'b1) && n < 40);
    bready <= 0;
    if (n >= 40)
      timed_out();
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd(input [11:0] a, input [7:0] ed, input [1:0] er);
    int n;
    n = 0;
    arv <= 1;
    ara <= a;
    do
    begin
      @(posedge i_core_clk);
      n++;
      if (arready === 1'b1)
        arv <= 0;
      if (n == 3)
        rready <= 1;
    end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 40);
    rready <= 0;
    if (n >= 40)
      timed_out();
    `CHK("rresp", er, rresp)
    `CHK("rdata", {24'h0000, ed}, rdata)
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset();
    tick(3);
    `CHK("oe", 8'h0A, poe)
    `CHK("pullup", 8'hF5, ppu)
    `CHK("reduced", 1'b0, red)
    rd(`OFF_PIN_DIRECTION, 8'h00, `RESP_OKAY);
    rd(`OFF_SYNC_CTRL_ONE, 8'h00, `RESP_OKAY);
    rd(`OFF_SYNC_CTRL_TWO, 8'h08, `RESP_OKAY);
    rd(`OFF_ASYNC0_CTRL_ONE, 8'h00, `RESP_OKAY);
    rd(`OFF_ASYNC1_CTRL_ONE, 8'h00, `RESP_OKAY);
    rd(12'h018, 8'h00, `RESP_SLVERR);
    wr(12'h020, 8'hFF, 4'h1, `RESP_SLVERR);
  endtask

  // released wired-or pins read the latch, not the low pin level
  task automatic t_gpio();
    wr(`OFF_PIN_DIRECTION, 8'hF0, 4'h1, `RESP_OKAY);
    wr(`OFF_PIN_DATA, 8'hA5, 4'h1, `RESP_OKAY);
    tick(3);
    `CHK("oe_hi", 4'hF, poe[7:4])
    `CHK("out_hi", 4'hA, pout[7:4])
    rd(`OFF_PIN_DATA, 8'hA8, `RESP_OKAY);
    wr(`OFF_SYNC_CTRL_ONE, 8'h20, 4'h1, `RESP_OKAY);
    tick(3);
    `CHK("wor_oe", 4'h5, poe[7:4])
    `CHK("wor_out", 4'h0, pout[7:4])
    rd(`OFF_PIN_DATA, 8'hA8, `RESP_OKAY);
    wr(`OFF_SYNC_CTRL_ONE, 8'h00, 4'h1, `RESP_OKAY);
  endtask

  task automatic t_async();
    ext_val <= 8'h04;
    wr(`OFF_PIN_DIRECTION, 8'h0F, 4'h1, `RESP_OKAY);
    wr(`OFF_PIN_DATA, 8'h0F, 4'h1, `RESP_OKAY);
    tick(3);
    `CHK("oe_lo", 4'hA, poe[3:0])
    `CHK("tx0_pin", 1'b0, pout[1])
    `CHK("tx1_pin", 1'b1, pout[3])
    `CHK("rx0", 1'b0, rcv0)
    `CHK("rx1", 1'b1, rcv1)
    wr(`OFF_ASYNC0_CTRL_ONE, 8'h80, 4'h1, `RESP_OKAY);
    wr(`OFF_ASYNC1_CTRL_ONE, 8'h80, 4'h1, `RESP_OKAY);
    tick(3);
    `CHK("loop_oe", 4'hF, poe[3:0])
    `CHK("loop_out", 4'hF, pout[3:0])
    `CHK("loop0", 1'b1, lp0)
    `CHK("loop1", 1'b1, lp1)
    wr(`OFF_ASYNC0_CTRL_ONE, 8'hC0, 4'h1, `RESP_OKAY);
    tick(3);
    `CHK("async_wor", 4'h3, poe[3:0])
    // second group bit releases the remaining pair of high outputs
    wr(`OFF_ASYNC1_CTRL_ONE, 8'hC0, 4'h1, `RESP_OKAY);
    tick(3);
    `CHK("async1_wor", 4'h0, poe[3:0])
    wr(`OFF_ASYNC0_CTRL_ONE, 8'h00, 4'h1, `RESP_OKAY);
    wr(`OFF_ASYNC1_CTRL_ONE, 8'h00, 4'h1, `RESP_OKAY);
    ext_val <= 8'h00;
  endtask

  task automatic t_sync();
    mask <= 4'hE;
    sval <= 4'hA;
    wr(`OFF_PIN_DIRECTION, 8'hB0, 4'h1, `RESP_OKAY);
    wr(`OFF_SYNC_CTRL_ONE, 8'h40, 4'h1, `RESP_OKAY);
    tick(3);
    `CHK("sync_oe", 4'hA, poe[7:4])
    `CHK("sync_sel", 1'b1, pout[7])
    `CHK("sync_mosi", 1'b1, pout[5])
    `CHK("sync_en", 1'b1, sen)
    wr(`OFF_SYNC_CTRL_ONE, 8'h00, 4'h1, `RESP_OKAY);
    wr(`OFF_PIN_DIRECTION, 8'h00, 4'h1, `RESP_OKAY);
  endtask

  // a write with no byte strobe must leave the register alone
  task automatic t_ctrl2();
    wr(`OFF_SYNC_CTRL_TWO, 8'h04, 4'h1, `RESP_OKAY);
    tick(3);
    `CHK("pull_off", 8'h00, ppu)
    `CHK("reduced_on", 1'b1, red)
    wr(`OFF_SYNC_CTRL_TWO, 8'hFF, 4'h0, `RESP_OKAY);
    rd(`OFF_SYNC_CTRL_TWO, 8'h04, `RESP_OKAY);
    wr(`OFF_SYNC_CTRL_TWO, 8'hFF, 4'h1, `RESP_OKAY);
    rd(`OFF_SYNC_CTRL_TWO, 8'h0D, `RESP_OKAY);
    `CHK("pin_ctrl", 1'b1, spc)
    `CHK("pull_on", 8'hF5, ppu)
  endtask

  // reset, then the scenarios in turn
  initial
  begin
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1;
    t_reset();
    t_gpio();
    t_async();
    t_sync();
    t_ctrl2();
    finish_test();
  end
endmodule
